// File: common/gpb_defs.svh
// Function
// - Eight-pin bank; each pin independently input or output.
// - Direction, level, latch, threshold, open-drain, slew, analog and pull-up registers.
// - Direction 1 disables driver; 0 drives latch value onto pin.
// - Level read returns sampled pins; level write updates the output latch.
// - Port writes are read-modify-write into the output latch.
// - Latch register write acts exactly like a level register write.
// - Latch register read returns latch contents, not pin levels.
// - Analog select disables the pin's digital input buffer.
// - Digital reads of analog pins return zero.
// - Direction bits still control drivers on analog pins.
// - Analog select never affects digital output driving.
// - Analog select bits reset to analog on pins 0-5; pins 6-7 come up digital.
// - Open-drain bit gives sink-only drive; clear gives push-pull.
// - Slew bit requests limited slew; clear requests maximum rate.
// - Threshold bit selects input threshold for reads.
// - Enabled peripheral blocks port output; pin stays readable.
// - Threshold 1 selects Schmitt trigger, 0 selects TTL.
// - Pull-up is disabled whenever the pin is an output.
// - After reset pins carry latch data; routing selects other functions.
`ifndef GPB_DEFS_SVH
`define GPB_DEFS_SVH

`define GPB_WIDTH        8
`define GPB_OFS_DIR      12'h000
`define GPB_OFS_LEVEL    12'h004
`define GPB_OFS_LATCH    12'h008
`define GPB_OFS_ANALOG   12'h00C
`define GPB_OFS_PULLUP   12'h010
`define GPB_OFS_ODRAIN   12'h014
`define GPB_OFS_SLEW     12'h018
`define GPB_OFS_THRESH   12'h01C
`define GPB_OFS_PERIPH   12'h020
`define GPB_OFS_GLOBAL   12'h024
`define GPB_RST_DIR      8'hFF
`define GPB_RST_LATCH    8'h00
`define GPB_RST_ANALOG   8'h3F
`define GPB_ANALOG_MASK  8'h3F
`define GPB_RST_PULLUP   8'hFF
`define GPB_RST_ODRAIN   8'h00
`define GPB_RST_SLEW     8'hFF
`define GPB_RST_THRESH   8'h00
`define GPB_RST_PERIPH   8'h00
`define GPB_RST_GLOBAL   1'b1
`define GPB_ADDR_W       12

`endif

// File: common/gpb_pkg.sv
package gpb_pkg;
  typedef enum logic [1:0] {
    GPB_IDLE   = 2'b00,
    GPB_ACCESS = 2'b01
  } gpb_phase_t;
endpackage

// File: core/gpb_sync.sv
`timescale 1ns/1ps
`default_nettype none
`include "gpb_defs.svh"
module gpb_sync (
  // Clock and reset
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  // Data
  input  wire logic [`GPB_WIDTH-1:0]  din,
  output logic      [`GPB_WIDTH-1:0]  dout
);
  logic [`GPB_WIDTH-1:0] stage1;

  // The first stage feeds only the second, to contain metastability.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1 <= `GPB_RST_LATCH;
      dout   <= `GPB_RST_LATCH;
    end else begin
      stage1 <= din;
      dout   <= stage1;
    end
  end
endmodule
`default_nettype wire

// File: core/gpb_pad_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "gpb_defs.svh"
module gpb_pad_ctrl (
  // Configuration
  input  wire logic [`GPB_WIDTH-1:0]  dir,
  input  wire logic [`GPB_WIDTH-1:0]  latch,
  input  wire logic [`GPB_WIDTH-1:0]  odrain,
  input  wire logic [`GPB_WIDTH-1:0]  pullup_req,
  input  wire logic                   pullup_off,
  input  wire logic [`GPB_WIDTH-1:0]  periph,
  input  wire logic [`GPB_WIDTH-1:0]  periph_out,
  // Pad controls
  output logic      [`GPB_WIDTH-1:0]  pin_out,
  output logic      [`GPB_WIDTH-1:0]  pin_oe,
  output logic      [`GPB_WIDTH-1:0]  pin_pu
);
  wire [`GPB_WIDTH-1:0] drive_val;
  wire [`GPB_WIDTH-1:0] drive_on;

  // Routing hands a pin to a peripheral; otherwise the latch owns it.
  assign drive_val = (periph & periph_out) | (~periph & latch);
  // Direction alone gates the driver, whatever the analog select says.
  assign drive_on  = ~dir;
  // Open-drain pins only sink: a high value releases the pin.
  assign pin_oe  = drive_on & ~(odrain & drive_val);
  assign pin_out = drive_val & ~odrain;
  assign pin_pu  = pullup_req & dir & {`GPB_WIDTH{~pullup_off}};
endmodule
`default_nettype wire

// File: core/gpb_port.sv
// The register addresses and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "gpb_defs.svh"
module gpb_port (
  // APB
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [`GPB_ADDR_W-1:0] paddr,
  input  wire logic [31:0]            pwdata,
  input  wire logic [3:0]             pstrb,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  // Pins
  input  wire logic [`GPB_WIDTH-1:0]  pin_in,
  output logic      [`GPB_WIDTH-1:0]  pin_out,
  output logic      [`GPB_WIDTH-1:0]  pin_oe,
  // Pad cell controls
  output logic      [`GPB_WIDTH-1:0]  pad_pull_up,
  output logic      [`GPB_WIDTH-1:0]  pad_slew_limit,
  output logic      [`GPB_WIDTH-1:0]  pad_schmitt,
  output logic      [`GPB_WIDTH-1:0]  pad_input_enable,
  // Peripheral routing
  input  wire logic [`GPB_WIDTH-1:0]  periph_out,
  output logic      [`GPB_WIDTH-1:0]  pin_digital_in
);
  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  logic [`GPB_WIDTH-1:0] bank_direction_bits;
  logic [`GPB_WIDTH-1:0] bank_output_latch;
  logic [`GPB_WIDTH-1:0] bank_analog_select;
  logic [`GPB_WIDTH-1:0] pull_up_enable_bits;
  logic [`GPB_WIDTH-1:0] open_drain_select_bits;
  logic [`GPB_WIDTH-1:0] slew_limit_bits;
  logic [`GPB_WIDTH-1:0] input_threshold_bits;
  logic [`GPB_WIDTH-1:0] periph_enable_bits;
  logic                  global_pull_up_disable;
  logic [`GPB_WIDTH-1:0] pins_synced;
  gpb_pkg::gpb_phase_t   phase;

  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  // Only the low lane carries register data; the upper lanes are ignored.
  function automatic logic [`GPB_WIDTH-1:0] merge_byte(
    input logic [`GPB_WIDTH-1:0] old_val,
    input logic [31:0]           wdata,
    input logic                  lane
  );
    merge_byte = lane ? wdata[`GPB_WIDTH-1:0] : old_val;
  endfunction

  // The whole address is compared, so an unaligned offset never aliases a register.
  function automatic logic addr_is(
    input logic [`GPB_ADDR_W-1:0] addr,
    input logic [`GPB_ADDR_W-1:0] offset
  );
    addr_is = (addr == offset);
  endfunction

  // The phase register keeps an enable that had no setup cycle from writing.
  wire bus_access = psel & penable & (phase == gpb_pkg::GPB_ACCESS);
  wire bus_wr     = bus_access & pwrite;
  wire rd_setup   = psel & ~penable & ~pwrite;
  wire hit_dir    = addr_is(paddr, `GPB_OFS_DIR);
  wire hit_level  = addr_is(paddr, `GPB_OFS_LEVEL);
  wire hit_latch  = addr_is(paddr, `GPB_OFS_LATCH);
  wire hit_analog = addr_is(paddr, `GPB_OFS_ANALOG);
  wire hit_pullup = addr_is(paddr, `GPB_OFS_PULLUP);
  wire hit_odrain = addr_is(paddr, `GPB_OFS_ODRAIN);
  wire hit_slew   = addr_is(paddr, `GPB_OFS_SLEW);
  wire hit_thresh = addr_is(paddr, `GPB_OFS_THRESH);
  wire hit_periph = addr_is(paddr, `GPB_OFS_PERIPH);
  wire hit_global = addr_is(paddr, `GPB_OFS_GLOBAL);
  wire hit_any    = hit_dir | hit_level | hit_latch | hit_analog | hit_pullup |
                    hit_odrain | hit_slew | hit_thresh | hit_periph | hit_global;
  wire lane0      = pstrb[0];

  // Write enables, one for each register.
  wire wr_dir     = bus_wr & hit_dir;
  wire wr_analog  = bus_wr & hit_analog;
  wire wr_pullup  = bus_wr & hit_pullup;
  wire wr_odrain  = bus_wr & hit_odrain;
  wire wr_slew    = bus_wr & hit_slew;
  wire wr_thresh  = bus_wr & hit_thresh;
  wire wr_periph  = bus_wr & hit_periph;
  wire wr_global  = bus_wr & hit_global & lane0;

  // Level and latch writes share one path into the latch.
  wire latch_wr = bus_wr & (hit_level | hit_latch);

  // A level write modifies the pin value as read; the strobe keeps
  // unstrobed bits at the read value, so a write is read-modify-write.
  wire [`GPB_WIDTH-1:0] next_latch = merge_byte(pin_digital_in, pwdata, lane0);

  // ------------------------------------------------------------
  // Input path
  // ------------------------------------------------------------
  gpb_sync u_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .din     (pin_in),
    .dout    (pins_synced)
  );

  // Analog pins have no digital buffer and read as zero.
  assign pad_input_enable = ~bank_analog_select;
  assign pin_digital_in   = pins_synced & ~bank_analog_select;
  assign pad_schmitt      = input_threshold_bits;
  assign pad_slew_limit   = slew_limit_bits;

  // ------------------------------------------------------------
  // Output path
  // ------------------------------------------------------------
  gpb_pad_ctrl u_pad (
    .dir        (bank_direction_bits),
    .latch      (bank_output_latch),
    .odrain     (open_drain_select_bits),
    .pullup_req (pull_up_enable_bits),
    .pullup_off (global_pull_up_disable),
    .periph     (periph_enable_bits),
    .periph_out (periph_out),
    .pin_out    (pin_out),
    .pin_oe     (pin_oe),
    .pin_pu     (pad_pull_up)
  );

  // ------------------------------------------------------------
  // Register writes
  // ------------------------------------------------------------
  // Every register keeps its value unless its own write enable is up.
  wire [`GPB_WIDTH-1:0] next_dir =
      wr_dir ? merge_byte(bank_direction_bits, pwdata, lane0) :
               bank_direction_bits;

  // A latch write loads even with the lane off: it then holds the pins as read.
  wire [`GPB_WIDTH-1:0] next_output_latch =
      latch_wr ? next_latch : bank_output_latch;

  // Only the six implemented analog bits can be set.
  wire [`GPB_WIDTH-1:0] next_analog =
      wr_analog ? (merge_byte(bank_analog_select, pwdata, lane0) & `GPB_ANALOG_MASK) :
                  bank_analog_select;

  wire [`GPB_WIDTH-1:0] next_pull_up =
      wr_pullup ? merge_byte(pull_up_enable_bits, pwdata, lane0) :
                  pull_up_enable_bits;

  wire [`GPB_WIDTH-1:0] next_open_drain =
      wr_odrain ? merge_byte(open_drain_select_bits, pwdata, lane0) :
                  open_drain_select_bits;

  wire [`GPB_WIDTH-1:0] next_slew =
      wr_slew ? merge_byte(slew_limit_bits, pwdata, lane0) :
                slew_limit_bits;

  wire [`GPB_WIDTH-1:0] next_threshold =
      wr_thresh ? merge_byte(input_threshold_bits, pwdata, lane0) :
                  input_threshold_bits;

  wire [`GPB_WIDTH-1:0] next_periph =
      wr_periph ? merge_byte(periph_enable_bits, pwdata, lane0) :
                  periph_enable_bits;

  wire next_pull_up_off = wr_global ? pwdata[0] : global_pull_up_disable;

  // ------------------------------------------------------------
  // Register storage
  // ------------------------------------------------------------
  // Pins come up as inputs, so nothing is driven before software picks a direction.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bank_direction_bits <= `GPB_RST_DIR;
    end else begin
      bank_direction_bits <= next_dir;
    end
  end

  // The latch starts at zero, so a pin first turned to output drives low.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bank_output_latch <= `GPB_RST_LATCH;
    end else begin
      bank_output_latch <= next_output_latch;
    end
  end

  // Analog after reset keeps the input buffers of pins 0-5 quiet when left floating.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bank_analog_select <= `GPB_RST_ANALOG;
    end else begin
      bank_analog_select <= next_analog;
    end
  end

  // Pull-up requests come up set, but the global disable holds them off.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pull_up_enable_bits <= `GPB_RST_PULLUP;
    end else begin
      pull_up_enable_bits <= next_pull_up;
    end
  end

  // Push-pull drive until software asks for open-drain.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      open_drain_select_bits <= `GPB_RST_ODRAIN;
    end else begin
      open_drain_select_bits <= next_open_drain;
    end
  end

  // Limited slew by default trades edge speed for less ringing on the board.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slew_limit_bits <= `GPB_RST_SLEW;
    end else begin
      slew_limit_bits <= next_slew;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      input_threshold_bits <= `GPB_RST_THRESH;
    end else begin
      input_threshold_bits <= next_threshold;
    end
  end

  // Routing starts off, so the latch owns every pin out of reset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      periph_enable_bits <= `GPB_RST_PERIPH;
    end else begin
      periph_enable_bits <= next_periph;
    end
  end

  // The global disable comes up set, so no pull-up is on out of reset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      global_pull_up_disable <= `GPB_RST_GLOBAL;
    end else begin
      global_pull_up_disable <= next_pull_up_off;
    end
  end

  // ------------------------------------------------------------
  // Bus phase tracking
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase <= gpb_pkg::GPB_IDLE;
    end else begin
      case (phase)
        gpb_pkg::GPB_IDLE:   phase <= (psel && !penable) ? gpb_pkg::GPB_ACCESS : gpb_pkg::GPB_IDLE;
        gpb_pkg::GPB_ACCESS: phase <= gpb_pkg::GPB_IDLE;
        default:             phase <= gpb_pkg::GPB_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Read data
  // ------------------------------------------------------------
  // The global disable reads back in bit 0 with the unused bits as zero.
  wire [`GPB_WIDTH-1:0] rd_global = {{(`GPB_WIDTH-1){1'b0}}, global_pull_up_disable};

  // Registered during setup so the access phase completes in one cycle.
  wire [`GPB_WIDTH-1:0] rd_sel =
      hit_dir    ? bank_direction_bits    :
      hit_level  ? pin_digital_in         :
      hit_latch  ? bank_output_latch      :
      hit_analog ? bank_analog_select     :
      hit_pullup ? pull_up_enable_bits    :
      hit_odrain ? open_drain_select_bits :
      hit_slew   ? slew_limit_bits        :
      hit_thresh ? input_threshold_bits   :
      hit_periph ? periph_enable_bits     :
      hit_global ? rd_global              :
                   `GPB_RST_LATCH;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata <= {24'h00_0000, rd_sel};
    end
  end

  assign pready  = 1'b1;
  assign pslverr = bus_access & ~hit_any;
endmodule
`default_nettype wire

// File: dv/gpb_pins.sv
`timescale 1ns/1ps
`default_nettype none
module gpb_pins (
  // Pad side of the bank
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  // Board side
  input  wire logic [7:0] ext_val,
  output logic      [7:0] pin_level
);
  // The board drives every pin that the port releases, so no pin ever floats.
  assign pin_level = (pin_oe & pin_out) | (~pin_oe & ext_val);
endmodule
`default_nettype wire

// File: dv/gpb_port_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "gpb_defs.svh"
module gpb_port_sva (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic [7:0]  pin_in,
  input wire logic [7:0]  pin_oe,
  input wire logic [7:0]  pad_pull_up,
  input wire logic [7:0]  pad_slew_limit,
  input wire logic [7:0]  pad_schmitt,
  input wire logic [7:0]  pad_input_enable,
  input wire logic [7:0]  pin_digital_in
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire acc = psel && penable;
  wire wr  = acc && pwrite && pstrb[0];
  wire bad = paddr[1:0] != 2'h0 || paddr > `GPB_OFS_GLOBAL;
  property p_err; acc |-> pslverr == bad; endproperty
  a_err: assert property (p_err) else $error("slave error flag wrong");
  property p_rdz; acc && !pwrite |-> prdata[31:8] == 24'h0; endproperty
  a_rdz: assert property (p_rdz) else $error("upper read bits set");
  property p_dir; wr && paddr == `GPB_OFS_DIR |=> (pin_oe & $past(pwdata[7:0])) == 8'h0; endproperty
  a_dir: assert property (p_dir) else $error("input pin driven");
  property p_slew; wr && paddr == `GPB_OFS_SLEW |=> pad_slew_limit == $past(pwdata[7:0]); endproperty
  a_slew: assert property (p_slew) else $error("slew control wrong");
  property p_thr; wr && paddr == `GPB_OFS_THRESH |=> pad_schmitt == $past(pwdata[7:0]); endproperty
  a_thr: assert property (p_thr) else $error("threshold control wrong");
  property p_ana;
    wr && paddr == `GPB_OFS_ANALOG |=>
      pad_input_enable == ~($past(pwdata[7:0]) & `GPB_ANALOG_MASK);
  endproperty
  a_ana: assert property (p_ana) else $error("input buffer enable wrong");
  property p_pu; (pad_pull_up & pin_oe) == 8'h0; endproperty
  a_pu: assert property (p_pu) else $error("pull-up on driven pin");
  property p_sync;
    ($stable(pin_in) && $stable(pad_input_enable) && $past(presetn, 3))[*3] |->
      pin_digital_in == (pin_in & pad_input_enable);
  endproperty
  a_sync: assert property (p_sync) else $error("synchronised input wrong");
  property p_rst; !$past(presetn) |-> pin_oe == 8'h0 && pad_input_enable == 8'hC0; endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
endmodule
bind gpb_port gpb_port_sva u_sva (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .pstrb, .prdata, .pslverr, .pin_in, .pin_oe, .pad_pull_up, .pad_slew_limit, .pad_schmitt,
  .pad_input_enable, .pin_digital_in);
`default_nettype wire

// File: dv/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "gpb_defs.svh"
module testbench;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, se;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, r;
  logic [3:0]  pstrb = 4'hF;
  logic [7:0]  pin_in, pin_out, pin_oe, pad_pull_up, pad_slew_limit, pad_schmitt;
  logic [7:0]  pad_input_enable, pin_digital_in, periph_out = 8'h00, ext = 8'hA5, d, l, e;
  int          fail_count = 0, checks = 0, cyc = 0, i;
  logic [11:0] ra[9] = '{`GPB_OFS_DIR, `GPB_OFS_LATCH, `GPB_OFS_ANALOG, `GPB_OFS_PULLUP,
    `GPB_OFS_ODRAIN, `GPB_OFS_SLEW, `GPB_OFS_THRESH, `GPB_OFS_PERIPH, `GPB_OFS_GLOBAL};
  logic [7:0]  rv[9] = '{`GPB_RST_DIR, `GPB_RST_LATCH, `GPB_RST_ANALOG, `GPB_RST_PULLUP,
    `GPB_RST_ODRAIN, `GPB_RST_SLEW, `GPB_RST_THRESH, `GPB_RST_PERIPH, 8'h01};
  gpb_port dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
    .pready, .pslverr, .pin_in, .pin_out, .pin_oe, .pad_pull_up, .pad_slew_limit, .pad_schmitt,
    .pad_input_enable, .periph_out, .pin_digital_in);
  gpb_pins pins_u (.pin_out, .pin_oe, .ext_val(ext), .pin_level(pin_in));
  always #12.5 pclk = ~pclk;
  // ----------------------------------------------------------------
  // Bus cycles and comparisons
  // ----------------------------------------------------------------
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    apb(1'b0, a, 32'h0);
    chk(r, {24'h0, exp});
  endtask
  function automatic logic [7:0] lvl(input logic [7:0] dr, lt, ex, an);
    return ((~dr & lt) | (dr & ex)) & ~an;
  endfunction
  task automatic wrap_up;
    $display("checks=%0d fail_count=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      wrap_up;
    end
  end
  initial begin
    void'($urandom(32'h5C86));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (i = 0; i < 9; i++) rd(ra[i], rv[i]);
    rd(`GPB_OFS_LEVEL, 8'h80);
    apb(1, 12'h040, 32'hFF); apb(0, 12'h040, 0);
    chk({31'h0, se}, 32'h1);
    chk(r, 32'h0);
    apb(1, `GPB_OFS_DIR, 0); apb(1, `GPB_OFS_LATCH, 8'hFF); apb(1, `GPB_OFS_ANALOG, 8'hFF);
    repeat (3) @(posedge pclk);
    rd(`GPB_OFS_LEVEL, lvl(8'h00, 8'hFF, ext, 8'h3F));
    chk({pin_oe, pad_input_enable}, 16'hFFC0);
    apb(1, `GPB_OFS_ANALOG, 0); apb(1, `GPB_OFS_DIR, 8'hFF); ext <= 8'h5A; pstrb <= 4'hE;
    repeat (3) @(posedge pclk);
    apb(1, `GPB_OFS_LATCH, 8'h00); pstrb <= 4'hF; rd(`GPB_OFS_LATCH, 8'h5A);
    for (i = 0; i < 20; i++) begin
      d = 8'($urandom); l = 8'($urandom); e = 8'($urandom);
      ext <= e;
      apb(1, `GPB_OFS_DIR, d);
      apb(1, i[0] ? `GPB_OFS_LEVEL : `GPB_OFS_LATCH, l);
      repeat (3) @(posedge pclk);
      rd(`GPB_OFS_LATCH, l);
      rd(`GPB_OFS_LEVEL, lvl(d, l, e, 8'h00));
      chk(pin_oe, 8'(~d));
    end
    apb(1, `GPB_OFS_DIR, 0); apb(1, `GPB_OFS_LATCH, 8'h0F); apb(1, `GPB_OFS_ODRAIN, 8'hFF);
    chk({pin_oe, pin_out & pin_oe}, 16'hF000);
    apb(1, `GPB_OFS_ODRAIN, 0); apb(1, `GPB_OFS_SLEW, 8'h3C);
    apb(1, `GPB_OFS_THRESH, 8'hC3);
    chk({pad_slew_limit, pad_schmitt}, 16'h3CC3);
    apb(1, `GPB_OFS_GLOBAL, 0); apb(1, `GPB_OFS_DIR, 8'hF0);
    chk(pad_pull_up, 8'hF0);
    apb(1, `GPB_OFS_DIR, 0); periph_out <= 8'h96; apb(1, `GPB_OFS_PERIPH, 8'hFF);
    repeat (3) @(posedge pclk);
    chk(pin_out, 8'h96);
    rd(`GPB_OFS_LEVEL, 8'h96);
    wrap_up;
  end
endmodule
`default_nettype wire
